// File: configurable_signed_multiplier.sv
// Configurable signed multiplier with sign-select registers and AXI4-Lite status.
// Behaviour
// - One shared A sign select and one B sign select govern the A and B halves; in square mode the A select governs both.
// - Operand A and B widths are parameters from 1 to 256 bits.
// - Product width is automatic (sum of operands) or restricted to 1..256 bits.
// - A narrower product width keeps only the most significant product bits.
// - Multiply A by B, or square A by multiplying it by itself.
// - Operand B may be a build-time constant instead of the input port.
// - Basic multiplier sign is chosen at build time, unsigned or signed.
// - The multiplier is combinational or pipelined with chosen output latency.
// - Nonzero latency needs the clock; latency 1 is the default, and zero latency is clockless.
// - Optional active-high asynchronous clear zeroes all pipeline stages at once.
// - Optional active-high clock enable advances stages; omitted means tied high.
// - Exactly one multiplier exists, all sharing one configuration.
// - A width, B width and result width are independently 1 to 256 bits.
// - Operand A is signed, unsigned or variable; variable follows A sign select.
// - Operand B is signed, unsigned or variable; variable follows B sign select.
// - Each sign select may pass an input register and an extra pipeline register.
// - Each sign register picks one of four clock sources, zero to three.
// - Each sign register takes clear zero, one, two, or no clear.
// - A fourth asynchronous clear may optionally be created.
// - Optional per-clock enables gate registers tied to that clock source.
// - Product is signed when any operand is signed, else unsigned.
// - Each numbered asynchronous clear is active high.
`timescale 1ns/1ps

module configurable_signed_multiplier #(
  parameter int operand_a_width = 16,
  parameter int operand_b_width = 16,
  parameter int product_width = operand_a_width + operand_b_width,
  parameter bit square_mode = 1'b0,
  parameter bit b_is_constant = 1'b0,
  parameter logic [operand_b_width-1:0] b_constant_value = '0,
  parameter mult_pkg::repr_t repr_a = mult_pkg::REPR_VARIABLE,
  parameter mult_pkg::repr_t repr_b = mult_pkg::REPR_VARIABLE,
  parameter int latency = 1,
  parameter bit has_pipeline_clear = 1'b1,
  parameter bit has_pipeline_enable = 1'b1,
  parameter logic [1:0] sign_input_reg = 2'b00,
  parameter logic [1:0] sign_pipe_reg = 2'b00,
  parameter logic [3:0] sign_input_clock = 4'h0,
  parameter logic [3:0] sign_pipe_clock = 4'h0,
  parameter logic [5:0] sign_input_clear = 6'h3f,
  parameter logic [5:0] sign_pipe_clear = 6'h3f,
  parameter bit fourth_clear = 1'b0,
  parameter bit clock_enables = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [operand_a_width-1:0] operand_a,
  input wire logic [operand_b_width-1:0] operand_b,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic pipeline_enable,
  input wire logic pipeline_clear,
  input wire logic [mult_pkg::CLOCK_SOURCES-1:0] clock_source_enable,
  input wire logic [mult_pkg::CLEAR_SOURCES-1:0] async_clear,
  output logic [product_width-1:0] product,
  input wire logic [mult_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [mult_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import mult_pkg::*;

  // ----------------------------------------------------------------
  // Derived widths
  // ----------------------------------------------------------------
  localparam int AW = operand_a_width;
  localparam int BW = square_mode ? operand_a_width : operand_b_width;
  localparam int FW = AW + BW;
  // Two operands, each with a 2-bit clock select and a 3-bit clear select.
  localparam int OPERANDS = 2;
  localparam int CLK_SEL_W = 2;
  localparam int CLR_SEL_W = 3;
  // One guard bit per operand keeps the extended product exact for any sign mix.
  localparam int XW = FW + OPERANDS + product_width;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int SW = product_width < DATA_W ? product_width : DATA_W;
  localparam int STRB_LANE = CONTROL_FREEZE_BIT / BYTE_W;

  logic [1:0] sign_eff;
  logic [1:0] sign_stage_in;
  logic [31:0] control;
  logic freeze;
  logic signed [AW:0] ext_a;
  logic signed [BW:0] ext_b;
  logic signed [XW-1:0] full;
  logic [product_width-1:0] result;
  logic advance;
  logic pipe_clear;

  assign sign_stage_in = {sign_b, sign_a};
  assign freeze = control[CONTROL_FREEZE_BIT];

  // ----------------------------------------------------------------
  // Sign-select path, one copy per operand
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < OPERANDS; gi++) begin : g_sign
      localparam logic [CLK_SEL_W-1:0] IN_CLK = sign_input_clock[CLK_SEL_W*gi +: CLK_SEL_W];
      localparam logic [CLK_SEL_W-1:0] PIPE_CLK = sign_pipe_clock[CLK_SEL_W*gi +: CLK_SEL_W];
      localparam logic [CLR_SEL_W-1:0] IN_CLR = sign_input_clear[CLR_SEL_W*gi +: CLR_SEL_W];
      localparam logic [CLR_SEL_W-1:0] PIPE_CLR = sign_pipe_clear[CLR_SEL_W*gi +: CLR_SEL_W];
      localparam repr_t REPR = (gi == 0) ? repr_a : repr_b;
      logic in_ena;
      logic pipe_ena;
      logic in_clr;
      logic pipe_clr;
      logic in_q;
      logic pipe_q;
      logic in_out;
      logic pipe_out;

      // Registers tied to a clock source step only with that source's enable.
      assign in_ena = clock_enables ? clock_source_enable[IN_CLK] : 1'b1;
      assign pipe_ena = clock_enables ? clock_source_enable[PIPE_CLK] : 1'b1;
      // The fourth clear exists only when it has been created.
      // The clear pins are decoded in logic, so every clear source must be free of glitches.
      assign in_clr = rst | ((IN_CLR != CLEAR_NONE) &&
                             ((IN_CLR != CLEAR_FOURTH) || fourth_clear) &&
                             async_clear[IN_CLR[1:0]]);
      assign pipe_clr = rst | ((PIPE_CLR != CLEAR_NONE) &&
                               ((PIPE_CLR != CLEAR_FOURTH) || fourth_clear) &&
                               async_clear[PIPE_CLR[1:0]]);

      always_ff @(posedge sys_clk or posedge in_clr) begin
        if (in_clr) begin
          in_q <= 1'b0;
        end else if (in_ena) begin
          in_q <= sign_stage_in[gi];
        end
      end

      always_ff @(posedge sys_clk or posedge pipe_clr) begin
        if (pipe_clr) begin
          pipe_q <= 1'b0;
        end else if (pipe_ena) begin
          pipe_q <= in_out;
        end
      end

      assign in_out = sign_input_reg[gi] ? in_q : sign_stage_in[gi];
      assign pipe_out = sign_pipe_reg[gi] ? pipe_q : in_out;

      // Fixed representations ignore the select; variable follows it.
      always_comb begin
        case (REPR)
          REPR_SIGNED: sign_eff[gi] = 1'b1;
          REPR_VARIABLE: sign_eff[gi] = pipe_out;
          default: sign_eff[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Multiplier core
  // ----------------------------------------------------------------
  // A single multiplier: every slice of A shares the A sign select, every slice of B the B sign select, except in square mode, where B takes the A sign select.
  assign ext_a = {sign_eff[SIGN_A_BIT] & operand_a[AW-1], operand_a};

  generate
    if (square_mode) begin : g_square
      assign ext_b = {sign_eff[SIGN_A_BIT] & operand_a[AW-1], operand_a};
    end else if (b_is_constant) begin : g_const
      assign ext_b = {sign_eff[SIGN_B_BIT] & b_constant_value[BW-1],
                      b_constant_value};
    end else begin : g_port
      assign ext_b = {sign_eff[SIGN_B_BIT] & operand_b[BW-1], operand_b};
    end
  endgenerate

  // One extra bit per operand makes the product signed if either side is.
  assign full = XW'(ext_a) * XW'(ext_b);

  // Narrow results keep the top bits; wide ones take the sign-extended product.
  generate
    if (product_width <= FW) begin : g_trunc
      assign result = full[FW-1 -: product_width];
    end else begin : g_wide
      assign result = full[product_width-1:0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output pipeline
  // ----------------------------------------------------------------
  assign advance = (has_pipeline_enable ? pipeline_enable : 1'b1) & ~freeze;
  assign pipe_clear = rst | (has_pipeline_clear & pipeline_clear);

  // Stage zero is the combinational result; the last stage drives the output.
  logic [product_width-1:0] stage [latency+1];
  assign stage[0] = result;

  genvar gk;
  generate
    for (gk = 1; gk <= latency; gk++) begin : g_pipe
      always_ff @(posedge sys_clk or posedge pipe_clear) begin
        if (pipe_clear) begin
          stage[gk] <= '0;
        end else if (advance) begin
          stage[gk] <= stage[gk-1];
        end
      end
    end
  endgenerate

  // With zero latency the product is combinational and no clock is used.
  assign product = stage[latency];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic write_hit;
  logic control_write;

  // A ready drops in the cycle after its handshake, so one beat is never taken twice.
  assign do_write = aw_held & w_held & ~bvalid;
  // Only the byte lane that holds the freeze bit can change CONTROL.
  assign control_write = do_write & (aw_addr == CONTROL_ADDR) & w_strb[STRB_LANE];

  // ----------------------------------------------------------------
  // AXI4-Lite write decode
  // ----------------------------------------------------------------
  // The mapped words answer OKAY even where they ignore the data.
  always_comb begin
    write_hit = 1'b0;
    if (aw_addr == CONTROL_ADDR) begin
      write_hit = 1'b1;
    end else if (aw_addr == PRODUCT_ADDR) begin
      write_hit = 1'b1;
    end else if (aw_addr == SIGN_STATE_ADDR) begin
      write_hit = 1'b1;
    end else if (aw_addr == WIDTHS_ADDR) begin
      write_hit = 1'b1;
    end else begin
      write_hit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      awready <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      awready <= ~aw_held & ~(awvalid & awready) & ~bvalid;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      wready <= 1'b0;
    end else begin
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      wready <= ~w_held & ~(wvalid & wready) & ~bvalid;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control <= CONTROL_RESET;
    end else if (control_write) begin
      control[CONTROL_FREEZE_BIT] <= w_data[CONTROL_FREEZE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] read_word;
  logic read_hit;

  always_comb begin
    read_word = '0;
    read_hit = 1'b1;
    if (araddr == CONTROL_ADDR) begin
      read_word = control;
    end else if (araddr == PRODUCT_ADDR) begin
      read_word[SW-1:0] = product[SW-1:0];
    end else if (araddr == SIGN_STATE_ADDR) begin
      read_word[SIGN_A_BIT] = sign_eff[SIGN_A_BIT];
      read_word[SIGN_B_BIT] = sign_eff[SIGN_B_BIT];
    end else if (araddr == WIDTHS_ADDR) begin
      read_word[WIDTH_A_LSB +: WIDTH_FIELD] = WIDTH_FIELD'(operand_a_width);
      read_word[WIDTH_B_LSB +: WIDTH_FIELD] = WIDTH_FIELD'(BW);
      read_word[WIDTH_P_LSB +: WIDTH_FIELD] = WIDTH_FIELD'(product_width);
    end else begin
      read_hit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      // Read data are captured at the address handshake and stand until rready is seen.
      arready <= ~rvalid & ~(arvalid & arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= read_word;
        rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule : configurable_signed_multiplier

// File: configurable_signed_multiplier_bench.sv
// Self-checking bench for the configurable signed multiplier.
`timescale 1ns/1ps
module configurable_signed_multiplier_bench;
  import mult_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, pipeline_enable = 1'b0, pipeline_clear = 1'b0;
  logic run = 1'b0, corner = 1'b0, freeze = 1'b0;
  logic [3:0] clock_source_enable = 4'hf, async_clear = 4'h0, wstrb = 4'hf;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] operand_a, operand_b;
  logic sign_a, sign_b, awready, wready, bvalid, arready, rvalid;
  logic [11:0] product;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, resp;
  logic [11:0] pipe[$] = '{12'h0, 12'h0};
  int checks = 0, n_fail = 0, cycles = 0;

  always #4 sys_clk = ~sys_clk;

  operand_feeder #(.aw(8), .bw(8)) operand_feeder_inst (.sys_clk(sys_clk), .run(run),
    .corner(corner), .operand_a(operand_a), .operand_b(operand_b), .sign_a(sign_a),
    .sign_b(sign_b));

  configurable_signed_multiplier #(.operand_a_width(8), .operand_b_width(8),
    .product_width(12), .latency(2)) configurable_signed_multiplier_inst (
    .sys_clk(sys_clk), .rst(rst), .operand_a(operand_a), .operand_b(operand_b),
    .sign_a(sign_a), .sign_b(sign_b), .pipeline_enable(pipeline_enable),
    .pipeline_clear(pipeline_clear), .clock_source_enable(clock_source_enable),
    .async_clear(async_clear), .product(product), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  function automatic logic [11:0] ref_mul(logic [7:0] a, logic [7:0] b, logic sa, logic sb);
    int x, y;
    x = sa ? int'($signed(a)) : int'(a);
    y = sb ? int'($signed(b)) : int'(b);
    return 12'((x * y) >>> 4);
  endfunction : ref_mul

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare

  task give_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    awprot <= 3'($urandom);
    wdata <= d;
    wstrb <= {3'($urandom), 1'b1};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!aw_done || !w_done) begin
      @(posedge sys_clk);
      if (!aw_done && awready) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic check_reg(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arprot <= 3'($urandom);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
    compare(rdata, e);
    compare(32'(rresp), 32'(er));
  endtask : check_reg

  // Reference pipeline: one entry enters per enabled edge, the oldest is the product.
  always @(posedge sys_clk or posedge pipeline_clear or posedge rst) begin
    if (rst || pipeline_clear) begin
      pipe = '{12'h0, 12'h0};
    end else if (pipeline_enable && !freeze) begin
      pipe.push_back(ref_mul(operand_a, operand_b, sign_a, sign_b));
      void'(pipe.pop_front());
    end
  end

  always @(negedge sys_clk) compare(32'(product), 32'(pipe[0]));

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h755a791e));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    check_reg(WIDTHS_ADDR, 32'h00c02008, RESP_OKAY);
    check_reg(CONTROL_ADDR, CONTROL_RESET, RESP_OKAY);
    check_reg(4'h2, 32'h0, RESP_SLVERR);
    axi_write(WIDTHS_ADDR, 32'h0, resp);
    compare(32'(resp), 32'(RESP_OKAY));
    check_reg(WIDTHS_ADDR, 32'h00c02008, RESP_OKAY);
    $display("register test done");
    run <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      corner <= i >= 200;
      run <= ($urandom % 8) != 0;
      rst <= i >= 300 && i < 303;
      pipeline_enable <= ($urandom % 4) != 0;
      pipeline_clear <= ($urandom % 40) == 0;
      async_clear <= 4'($urandom);
      clock_source_enable <= 4'($urandom);
    end
    @(posedge sys_clk);
    pipeline_enable <= 1'b0;
    pipeline_clear <= 1'b0;
    $display("stream test done");
    repeat (4) begin
      @(posedge sys_clk);
      run <= 1'b1;
      @(posedge sys_clk);
      run <= 1'b0;
      @(negedge sys_clk);
      check_reg(SIGN_STATE_ADDR, {30'h0, sign_b, sign_a}, RESP_OKAY);
    end
    $display("sign test done");
    axi_write(CONTROL_ADDR, 32'h1, resp);
    freeze = 1'b1;
    check_reg(PRODUCT_ADDR, 32'(pipe[0]), RESP_OKAY);
    run <= 1'b1;
    pipeline_enable <= 1'b1;
    repeat (20) @(posedge sys_clk);
    run <= 1'b0;
    pipeline_enable <= 1'b0;
    axi_write(CONTROL_ADDR, 32'h0, resp);
    freeze = 1'b0;
    run <= 1'b1;
    pipeline_enable <= 1'b1;
    repeat (10) @(posedge sys_clk);
    $display("freeze test done");
    give_verdict();
  end
endmodule : configurable_signed_multiplier_bench

// File: mult_pkg.sv
// Shared constants for the configurable signed multiplier.
package mult_pkg;

  // ----------------------------------------------------------------
  // Operand representation
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    REPR_UNSIGNED = 2'b00,
    REPR_SIGNED = 2'b01,
    REPR_VARIABLE = 2'b10
  } repr_t;

  // ----------------------------------------------------------------
  // Clock and clear sources
  // ----------------------------------------------------------------
  localparam int CLOCK_SOURCES = 4;
  localparam int CLEAR_SOURCES = 4;
  localparam logic [2:0] CLEAR_NONE = 3'h7;
  localparam logic [2:0] CLEAR_FOURTH = 3'h3;
  localparam int WIDTH_MIN = 1;
  localparam int WIDTH_MAX = 256;
  localparam int MULTIPLIER_COUNT = 1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] PRODUCT_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] SIGN_STATE_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] WIDTHS_ADDR = 4'hc;
  localparam int CONTROL_FREEZE_BIT = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0;
  localparam int SIGN_A_BIT = 0;
  localparam int SIGN_B_BIT = 1;
  localparam int WIDTH_A_LSB = 0;
  localparam int WIDTH_B_LSB = 10;
  localparam int WIDTH_P_LSB = 20;
  localparam int WIDTH_FIELD = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mult_pkg

// File: mult_sva.sv
// Checker for the multiplier's datapath and status port.
`timescale 1ns/1ps
module mult_sva #(
  parameter int operand_a_width = 8,
  parameter int operand_b_width = 8,
  parameter int product_width = 12
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [operand_a_width-1:0] operand_a,
  input wire logic [operand_b_width-1:0] operand_b,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic pipeline_enable,
  input wire logic pipeline_clear,
  input wire logic [product_width-1:0] product,
  input wire logic [mult_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [mult_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  import mult_pkg::*;
  localparam int FW = operand_a_width + operand_b_width;
  logic signed [FW:0] full;
  logic [FW-1:0] uprod;
  logic frozen;
  logic aw_seen;
  logic w_seen;
  logic [ADDR_W-1:0] aw_seen_addr;
  logic w_seen_bit;
  logic w_seen_lane;
  wire [product_width-1:0] exp_p = full[FW-1 -: product_width];
  wire [product_width-1:0] exp_u = uprod[FW-1 -: product_width];
  wire adv = pipeline_enable && !pipeline_clear && !frozen;
  wire [1:0] signs = {sign_b, sign_a};
  always_comb begin
    full = $signed({sign_a & operand_a[operand_a_width-1], operand_a}) *
      $signed({sign_b & operand_b[operand_b_width-1], operand_b});
    uprod = operand_a * operand_b;
  end
  // Mirror of the held beats: CONTROL changes at the edge where both are held.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_seen <= 1'b0;
      w_seen <= 1'b0;
      aw_seen_addr <= '0;
      w_seen_bit <= 1'b0;
      w_seen_lane <= 1'b0;
      frozen <= 1'b0;
    end else if (aw_seen && w_seen) begin
      aw_seen <= 1'b0;
      w_seen <= 1'b0;
      if (aw_seen_addr == CONTROL_ADDR && w_seen_lane) begin
        frozen <= w_seen_bit;
      end
    end else begin
      if (awvalid && awready) begin
        aw_seen <= 1'b1;
        aw_seen_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_seen <= 1'b1;
        w_seen_bit <= wdata[CONTROL_FREEZE_BIT];
        w_seen_lane <= wstrb[CONTROL_FREEZE_BIT / 8];
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  clear_zero_a: assert property (pipeline_clear |-> product == '0)
    else $error("product not zero under clear");
  idle_hold_a: assert property (!pipeline_enable && !pipeline_clear |=>
    pipeline_clear || $stable(product)) else $error("product moved while disabled");
  product_delay_a: assert property (adv [*2] |=>
    pipeline_clear || product == $past(exp_p, 2)) else $error("product value or delay wrong");
  unsigned_prod_a: assert property (adv && !sign_a && !sign_b ##1 adv |=>
    pipeline_clear || product == $past(exp_u, 2)) else $error("unsigned product wrong");
  sign_state_a: assert property (arvalid && arready && araddr == SIGN_STATE_ADDR |=>
    rvalid && rdata[1:0] == $past(signs)) else $error("sign state wrong");
  widths_reg_a: assert property (arvalid && arready && araddr == WIDTHS_ADDR |=>
    rvalid && rdata == {2'h0, 10'(product_width), 10'(operand_b_width), 10'(operand_a_width)})
    else $error("widths register wrong");
  freeze_hold_a: assert property (frozen && !pipeline_clear |=>
    pipeline_clear || $stable(product)) else $error("product moved while frozen");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
endmodule : mult_sva

bind configurable_signed_multiplier mult_sva #(.operand_a_width(operand_a_width),
  .operand_b_width(operand_b_width), .product_width(product_width)) mult_sva_inst (
  .sys_clk(sys_clk), .rst(rst), .operand_a(operand_a), .operand_b(operand_b),
  .sign_a(sign_a), .sign_b(sign_b), .pipeline_enable(pipeline_enable),
  .pipeline_clear(pipeline_clear), .product(product), .awaddr(awaddr), .wdata(wdata),
  .awvalid(awvalid), .awready(awready), .wstrb(wstrb),
  .wvalid(wvalid), .wready(wready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid));

// File: operand_feeder.sv
// Fabric-side model that feeds operands and sign selects to the multiplier.
`timescale 1ns/1ps
module operand_feeder #(
  parameter int aw = 8,
  parameter int bw = 8
) (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic corner,
  output logic [aw-1:0] operand_a = '0,
  output logic [bw-1:0] operand_b = '0,
  output logic sign_a = 1'b0,
  output logic sign_b = 1'b0
);
  logic [31:0] r;
  // Corner mode picks zero, all ones, largest positive and most negative.
  always @(posedge sys_clk) begin
    r = $urandom;
    if (run && corner) begin
      operand_a <= r[1] ? {r[0], {(aw-1){!r[0]}}} : {aw{r[0]}};
      operand_b <= r[3] ? {r[2], {(bw-1){!r[2]}}} : {bw{r[2]}};
    end else if (run) begin
      operand_a <= aw'(r);
      operand_b <= bw'(r >> 16);
    end
    if (run) begin
      {sign_b, sign_a} <= r[5:4];
    end
  end
endmodule : operand_feeder
